/* core/iesl_status_link.sv */
`timescale 1ns/100ps
// What this block does
// - with errors not ignored, a message with a receive error is not executed
// - with errors not ignored, an errored string byte and all later ones are dropped
// - after reset or reinitialise, receive errors are ignored
// - ignoring errors executes everything and reports serial error code none
// - ignore-errors command with no argument returns the present setting
// - ignore-errors setting holds until rewritten, reinitialised or powered off
// - receive errors are parity, overrun, framing or buffer overflow
// - remote-enable 1 asserts the bus REN line, 0 releases it
// - remote-enable with argument when not system controller keeps REN, records fault
// - remote-enable without argument returns remote status, 1 remote 0 local
// - status fields go out numeric or symbolic as selected
// - continuous option sends the report after every processed message that ends while no report is being sent
// - status command without argument turns continuous reporting off
// - report is condition, bus error, serial error, count, each terminated
// - condition word is 16 bits, one bit per active condition
// - condition bit 15 is set on any bus or serial error
// - bits 14 timeout, 13 end, 12 service request, 11-9 reserved, 8 done
// - bits 7 lockout, 6 remote, 5 in charge, 4 ATN, 3..0 addressed states
// - bus and serial error fields each hold a single code
// - count equals bytes moved by the last read, write or command send
// - serial codes: 0 none, 1 parity, 2 overrun, 3 overflow, 4 framing
// - bus codes: 0 none, 1 not in charge, 2 no listeners, 4, 5, 6
// - first three fields update at message end, count after transfers only
// - numeric report precedes symbolic report when both are selected
module iesl_status_link
   import iesl_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        REINIT,
   input  wire logic        CMD_VALID,
   input  wire iesl_op_type CMD_OP,
   input  wire logic        CMD_HAS_ARG,
   input  wire logic [2:0]  CMD_ARG,
   input  wire logic        MSG_END,
   input  wire logic [4:0]  MSG_BUS_ERR,
   input  wire logic        XFER_DONE,
   input  wire logic [15:0] XFER_COUNT,
   input  wire logic        RX_VALID,
   input  wire logic        RX_IN_STRING,
   input  wire logic        RX_PARITY_ERR,
   input  wire logic        RX_OVERRUN_ERR,
   input  wire logic        RX_FRAMING_ERR,
   input  wire logic        RX_OVERFLOW_ERR,
   input  wire logic        SYS_CTRL,
   input  wire logic [14:0] COND_FLAGS,
   input  wire logic        ITEM_READY,
   output logic             BYTE_VALID,
   output logic             BYTE_KEEP,
   output logic             EXEC_VALID,
   output logic             EXEC_ALLOW,
   output logic             REPLY_VALID,
   output logic [15:0]      REPLY_VALUE,
   output logic             REN_OUT,
   output logic             REN_OE_N,
   output logic [15:0]      COND_WORD,
   output logic [4:0]       BUS_ERR_CODE,
   output logic [2:0]       SER_ERR_CODE,
   output logic [15:0]      XFER_TOTAL,
   output logic             ITEM_VALID,
   output logic             ITEM_SYM,
   output logic [1:0]       ITEM_FIELD,
   output logic [15:0]      ITEM_VALUE
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic        ignore_r;
   logic        ren_oe_n_r;
   logic [2:0]  msg_ser_r;
   logic        drop_r;
   logic [4:0]  msg_bus_r;
   logic        cont_r;
   logic        num_r;
   logic        sym_r;
   logic        stat_req_r;
   logic [15:0] cond_r;
   logic [4:0]  bus_r;
   logic [2:0]  ser_r;
   logic [15:0] count_r;
   logic        byte_valid_r;
   logic        byte_keep_r;
   logic        exec_valid_r;
   logic        exec_allow_r;
   logic        reply_valid_r;
   logic [15:0] reply_value_r;
   logic        item_valid_q;
   logic        item_sym_q;
   logic [1:0]  item_field_q;
   logic [15:0] item_value_q;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic        do_ign_set;
   logic        do_ign_query;
   logic        do_ren_set;
   logic        do_ren_query;
   logic        ren_refused;
   logic        do_stat_set;
   logic        do_stat_off;
   logic        rx_err_any;
   logic [2:0]  rx_err_code;
   logic        byte_drop;
   logic [2:0]  ser_nxt;
   logic [4:0]  bus_nxt;
   logic [15:0] cond_nxt;
   logic        report_go;
   logic        rep_numeric;
   logic        rep_symbolic;
   logic        seq_item_valid;
   logic        seq_item_sym;
   logic [1:0]  seq_item_field;
   logic [15:0] seq_item_value;
   logic        item_ready_int;

   assign do_ign_set   = CMD_VALID && CMD_OP == IESL_OP_IGNORE_ERR && CMD_HAS_ARG;
   assign do_ign_query = CMD_VALID && CMD_OP == IESL_OP_IGNORE_ERR && !CMD_HAS_ARG;
   assign do_ren_set   = CMD_VALID && CMD_OP == IESL_OP_REMOTE_EN && CMD_HAS_ARG && SYS_CTRL;
   assign ren_refused  = CMD_VALID && CMD_OP == IESL_OP_REMOTE_EN && CMD_HAS_ARG && !SYS_CTRL;
   assign do_ren_query = CMD_VALID && CMD_OP == IESL_OP_REMOTE_EN && !CMD_HAS_ARG;
   assign do_stat_set  = CMD_VALID && CMD_OP == IESL_OP_STATUS && CMD_HAS_ARG;
   assign do_stat_off  = CMD_VALID && CMD_OP == IESL_OP_STATUS && !CMD_HAS_ARG;

   // one code per receive error, fixed priority when several fire together
   assign rx_err_any  = RX_VALID && (RX_PARITY_ERR || RX_OVERRUN_ERR ||
                                     RX_FRAMING_ERR || RX_OVERFLOW_ERR);
   assign rx_err_code = RX_PARITY_ERR   ? IESL_PARITY_FAULT :
                        RX_OVERRUN_ERR  ? IESL_OVERRUN_FAULT :
                        RX_OVERFLOW_ERR ? IESL_BUFFER_OVERFLOW_FAULT :
                        RX_FRAMING_ERR  ? IESL_FRAMING_FAULT : IESL_NO_LINK_FAULT;

   // drop from the errored byte to the end of the string
   assign byte_drop = !ignore_r && RX_IN_STRING && (drop_r || rx_err_any);

   // serial code is none while errors are ignored; an error on the closing byte still counts
   assign ser_nxt  = ignore_r ? IESL_NO_LINK_FAULT :
                     (rx_err_any && msg_ser_r == IESL_NO_LINK_FAULT) ? rx_err_code :
                     msg_ser_r;
   // a local refusal wins over whatever the other functions report
   assign bus_nxt  = (msg_bus_r != IESL_NO_BUS_FAULT) ? msg_bus_r :
                     ren_refused ? IESL_NOT_SYS_CTRL_FAULT : MSG_BUS_ERR;
   assign cond_nxt = {(bus_nxt != IESL_NO_BUS_FAULT) || (ser_nxt != IESL_NO_LINK_FAULT),
                      COND_FLAGS} & ~IESL_COND_RSV_MASK;

   // continuous mode reports current values; a one-shot request reports stored ones
   assign report_go    = MSG_END && (cont_r || stat_req_r);
   assign rep_numeric  = num_r;
   assign rep_symbolic = sym_r;

   // ----------------------------------------
   // report sequencer
   // ----------------------------------------
   iesl_rpt_if rpt ();

   assign rpt.start    = report_go;
   assign rpt.numeric  = rep_numeric;
   assign rpt.symbolic = rep_symbolic;
   assign rpt.cond     = cont_r ? cond_nxt : cond_r;
   assign rpt.bus_err  = cont_r ? bus_nxt : bus_r;
   assign rpt.ser_err  = cont_r ? ser_nxt : ser_r;
   assign rpt.count    = (cont_r && XFER_DONE) ? XFER_COUNT : count_r;

   // registered output stage; the sequencer only moves when the stage is free
   assign item_ready_int = !item_valid_q || ITEM_READY;

   iesl_report_seq u_seq (
      .clk        (CLK),
      .nrst       (NRST),
      .rpt        (rpt),
      .item_ready (item_ready_int),
      .item_valid (seq_item_valid),
      .item_sym   (seq_item_sym),
      .item_field (seq_item_field),
      .item_value (seq_item_value)
   );

   // ----------------------------------------
   // settings
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         ignore_r <= IESL_IGNORE_RESET;
      end else if (do_ign_set) begin
         ignore_r <= CMD_ARG[IESL_ARG_BOOL_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         ren_oe_n_r <= 1'b1;
      end else if (do_ren_set) begin
         ren_oe_n_r <= !CMD_ARG[IESL_ARG_BOOL_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         cont_r <= 1'b0;
         num_r  <= 1'b0;
         sym_r  <= 1'b0;
      end else if (do_stat_set) begin
         cont_r <= CMD_ARG[IESL_ARG_CONT_BIT];
         num_r  <= CMD_ARG[IESL_ARG_NUM_BIT];
         sym_r  <= CMD_ARG[IESL_ARG_SYM_BIT];
      end else if (do_stat_off) begin
         cont_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // per-message tracking
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         msg_ser_r  <= IESL_NO_LINK_FAULT;
         drop_r     <= 1'b0;
         msg_bus_r  <= IESL_NO_BUS_FAULT;
         stat_req_r <= 1'b0;
      end else if (MSG_END) begin
         msg_ser_r  <= IESL_NO_LINK_FAULT;
         drop_r     <= 1'b0;
         msg_bus_r  <= IESL_NO_BUS_FAULT;
         stat_req_r <= 1'b0;
      end else begin
         if (rx_err_any && msg_ser_r == IESL_NO_LINK_FAULT) begin
            msg_ser_r <= rx_err_code;
         end
         if (RX_VALID) begin
            drop_r <= byte_drop;
         end
         if (ren_refused) begin
            msg_bus_r <= IESL_NOT_SYS_CTRL_FAULT;
         end
         if (do_stat_set) begin
            stat_req_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // status fields
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         cond_r <= IESL_COND_RESET;
         bus_r  <= IESL_NO_BUS_FAULT;
         ser_r  <= IESL_NO_LINK_FAULT;
      end else if (MSG_END) begin
         cond_r <= cond_nxt;
         bus_r  <= bus_nxt;
         ser_r  <= ser_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST || REINIT) begin
         count_r <= 16'h0000;
      end else if (XFER_DONE) begin
         count_r <= XFER_COUNT;
      end
   end

   // ----------------------------------------
   // pulses and answers
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         byte_valid_r  <= 1'b0;
         byte_keep_r   <= 1'b0;
         exec_valid_r  <= 1'b0;
         exec_allow_r  <= 1'b0;
         reply_valid_r <= 1'b0;
         reply_value_r <= 16'h0000;
      end else begin
         byte_valid_r  <= RX_VALID;
         byte_keep_r   <= RX_VALID && !byte_drop;
         exec_valid_r  <= MSG_END;
         exec_allow_r  <= MSG_END && (ser_nxt == IESL_NO_LINK_FAULT);
         reply_valid_r <= do_ign_query || do_ren_query;
         if (do_ign_query) begin
            reply_value_r <= {15'h0000, ignore_r};
         end else if (do_ren_query) begin
            reply_value_r <= {15'h0000, COND_FLAGS[IESL_COND_REM_BIT]};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         item_valid_q <= 1'b0;
         item_sym_q   <= 1'b0;
         item_field_q <= IESL_FIELD_COND;
         item_value_q <= 16'h0000;
      end else if (item_ready_int) begin
         item_valid_q <= seq_item_valid;
         item_sym_q   <= seq_item_sym;
         item_field_q <= seq_item_field;
         item_value_q <= seq_item_value;
      end
   end

   // REN is active low and open drain: the pin is pulled low while enabled
   assign REN_OUT      = 1'b0;
   assign REN_OE_N     = ren_oe_n_r;
   assign BYTE_VALID   = byte_valid_r;
   assign BYTE_KEEP    = byte_keep_r;
   assign EXEC_VALID   = exec_valid_r;
   assign EXEC_ALLOW   = exec_allow_r;
   assign REPLY_VALID  = reply_valid_r;
   assign REPLY_VALUE  = reply_value_r;
   assign COND_WORD    = cond_r;
   assign BUS_ERR_CODE = bus_r;
   assign SER_ERR_CODE = ser_r;
   assign XFER_TOTAL   = count_r;
   assign ITEM_VALID   = item_valid_q;
   assign ITEM_SYM     = item_sym_q;
   assign ITEM_FIELD   = item_field_q;
   assign ITEM_VALUE   = item_value_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   chk_errored_msg_blocked: assert property (
      (MSG_END && !ignore_r && msg_ser_r != IESL_NO_LINK_FAULT) |=> !EXEC_ALLOW)
      else $error("message with receive error was allowed to run");

   chk_string_drop_tail: assert property (
      (RX_VALID && RX_IN_STRING && !ignore_r && !MSG_END && (rx_err_any || drop_r))
      |=> !BYTE_KEEP)
      else $error("errored string byte or a later one was kept");
   chk_reinit_ignores: assert property (REINIT |=> ignore_r)
      else $error("reinitialise did not restore ignore setting");
   chk_ignored_code_none: assert property (
      (MSG_END && ignore_r) |=> (SER_ERR_CODE == IESL_NO_LINK_FAULT && EXEC_ALLOW))
      else $error("ignored receive error leaked into report");
   chk_ren_refused: assert property (
      ren_refused |=> ($stable(REN_OE_N) && msg_bus_r == IESL_NOT_SYS_CTRL_FAULT))
      else $error("remote enable changed without system control");

   chk_ren_follows: assert property (
      (do_ren_set && !REINIT) |=> (REN_OE_N == !$past(CMD_ARG[IESL_ARG_BOOL_BIT])))
      else $error("remote enable line does not follow argument");

   chk_error_sign_bit: assert property (
      (COND_WORD[IESL_COND_ERR_BIT] == (BUS_ERR_CODE != IESL_NO_BUS_FAULT ||
                                        SER_ERR_CODE != IESL_NO_LINK_FAULT)) &&
      (COND_WORD[IESL_COND_RSV_HI:IESL_COND_RSV_LO] == 3'h0))
      else $error("condition word error or reserved bits wrong");

   chk_count_hold: assert property (
      (!XFER_DONE && !REINIT) |=> $stable(XFER_TOTAL))
      else $error("transfer count moved without a transfer");

   chk_cont_report: assert property (
      (MSG_END && cont_r && (num_r || sym_r) && !rpt.busy && item_ready_int)
      |=> ##[1:2] ITEM_VALID)
      else $error("continuous report not started after message");

endmodule : iesl_status_link

/* core/iesl_pkg.sv */
package iesl_pkg;

   // ----------------------------------------
   // commands handed over by the interpreter
   // ----------------------------------------
   typedef enum logic [1:0] {
      IESL_OP_IGNORE_ERR,
      IESL_OP_REMOTE_EN,
      IESL_OP_STATUS
   } iesl_op_type;

   // ----------------------------------------
   // argument field positions
   // ----------------------------------------
   localparam int unsigned IESL_ARG_BOOL_BIT  = 0;
   localparam int unsigned IESL_ARG_NUM_BIT   = 0;
   localparam int unsigned IESL_ARG_SYM_BIT   = 1;
   localparam int unsigned IESL_ARG_CONT_BIT  = 2;

   // ----------------------------------------
   // condition word layout
   // ----------------------------------------
   localparam int unsigned IESL_COND_ERR_BIT  = 15;
   localparam int unsigned IESL_COND_TIME_LIMIT_HIT_BIT = 14;
   localparam int unsigned IESL_COND_END_BIT  = 13;
   localparam int unsigned IESL_COND_SRQ_BIT  = 12;
   localparam int unsigned IESL_COND_RSV_HI   = 11;
   localparam int unsigned IESL_COND_RSV_LO   = 9;
   localparam int unsigned IESL_COND_OP_DONE_FLAG_BIT = 8;
   localparam int unsigned IESL_COND_LOK_BIT  = 7;
   localparam int unsigned IESL_COND_REM_BIT  = 6;
   localparam logic [15:0] IESL_COND_RESET    = 16'h0000;
   localparam logic [15:0] IESL_COND_RSV_MASK = 16'h0E00;

   // ----------------------------------------
   // bus error codes
   // ----------------------------------------
   localparam logic [4:0] IESL_NO_BUS_FAULT        = 5'h00;
   localparam logic [4:0] IESL_NOT_IN_CHARGE_FAULT = 5'h01;
   localparam logic [4:0] IESL_NO_LISTENER_FAULT   = 5'h02;
   localparam logic [4:0] IESL_BAD_ARGUMENT_FAULT  = 5'h04;
   localparam logic [4:0] IESL_NOT_SYS_CTRL_FAULT  = 5'h05;
   localparam logic [4:0] IESL_IO_ABORT_FAULT      = 5'h06;

   // ----------------------------------------
   // serial error codes
   // ----------------------------------------
   localparam logic [2:0] IESL_NO_LINK_FAULT         = 3'h0;
   localparam logic [2:0] IESL_PARITY_FAULT          = 3'h1;
   localparam logic [2:0] IESL_OVERRUN_FAULT         = 3'h2;
   localparam logic [2:0] IESL_BUFFER_OVERFLOW_FAULT = 3'h3;
   localparam logic [2:0] IESL_FRAMING_FAULT         = 3'h4;

   // ----------------------------------------
   // reset values and report layout
   // ----------------------------------------
   localparam logic       IESL_IGNORE_RESET = 1'b1;
   localparam logic [1:0] IESL_FIELD_COND   = 2'h0;
   localparam logic [1:0] IESL_FIELD_BUS    = 2'h1;
   localparam logic [1:0] IESL_FIELD_SER    = 2'h2;
   localparam logic [1:0] IESL_FIELD_COUNT  = 2'h3;

endpackage : iesl_pkg

/* core/iesl_rpt_if.sv */
`timescale 1ns/100ps
interface iesl_rpt_if;
   logic        start;
   logic        numeric;
   logic        symbolic;
   logic [15:0] cond;
   logic [4:0]  bus_err;
   logic [2:0]  ser_err;
   logic [15:0] count;
   logic        busy;

   modport ctrl (output start, numeric, symbolic, cond, bus_err, ser_err, count, input busy);
   modport seq  (input start, numeric, symbolic, cond, bus_err, ser_err, count, output busy);
endinterface : iesl_rpt_if

/* core/iesl_report_seq.sv */
`timescale 1ns/100ps
module iesl_report_seq
   import iesl_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  nrst,
   iesl_rpt_if.seq    rpt,
   input  wire logic  item_ready,
   output logic       item_valid,
   output logic       item_sym,
   output logic [1:0] item_field,
   output logic [15:0] item_value
);

   typedef enum logic [1:0] {IESL_RS_IDLE, IESL_RS_SEND} iesl_rs_type;

   iesl_rs_type state_r;
   logic        sym_r;
   logic        two_pass_r;
   logic [1:0]  field_r;
   logic [15:0] cond_r;
   logic [4:0]  bus_r;
   logic [2:0]  ser_r;
   logic [15:0] count_r;
   logic [15:0] value_sel;
   logic        last_field;
   logic        taken;

   assign taken      = item_valid && item_ready;
   assign last_field = (field_r == IESL_FIELD_COUNT);
   // fields leave in fixed order: condition, bus error, serial error, count
   assign value_sel  = (field_r == IESL_FIELD_COND) ? cond_r :
                       (field_r == IESL_FIELD_BUS)  ? {11'h000, bus_r} :
                       (field_r == IESL_FIELD_SER)  ? {13'h0000, ser_r} : count_r;
   assign item_value = value_sel;
   assign item_field = field_r;
   assign item_sym   = sym_r;
   assign item_valid = (state_r == IESL_RS_SEND);
   assign rpt.busy   = (state_r == IESL_RS_SEND);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r    <= IESL_RS_IDLE;
         sym_r      <= 1'b0;
         two_pass_r <= 1'b0;
         field_r    <= IESL_FIELD_COND;
         cond_r     <= IESL_COND_RESET;
         bus_r      <= IESL_NO_BUS_FAULT;
         ser_r      <= IESL_NO_LINK_FAULT;
         count_r    <= 16'h0000;
      end else begin
         unique case (state_r)
            IESL_RS_IDLE: begin
               if (rpt.start && (rpt.numeric || rpt.symbolic)) begin
                  state_r    <= IESL_RS_SEND;
                  // numeric pass goes first when both are asked for
                  sym_r      <= !rpt.numeric;
                  two_pass_r <= rpt.numeric && rpt.symbolic;
                  field_r    <= IESL_FIELD_COND;
                  cond_r     <= rpt.cond;
                  bus_r      <= rpt.bus_err;
                  ser_r      <= rpt.ser_err;
                  count_r    <= rpt.count;
               end
            end
            IESL_RS_SEND: begin
               if (taken) begin
                  field_r <= field_r + 2'h1;
                  if (last_field && two_pass_r) begin
                     two_pass_r <= 1'b0;
                     sym_r      <= 1'b1;
                  end else if (last_field) begin
                     state_r <= IESL_RS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_numeric_first: assert property (
      (state_r == IESL_RS_IDLE && rpt.start && rpt.numeric && rpt.symbolic)
      |=> !item_sym) else $error("symbolic pass came before numeric pass");

   chk_field_order: assert property (
      (taken && !last_field) |=> (item_field == $past(item_field) + 2'h1))
      else $error("report fields left out of order");

endmodule : iesl_report_seq

/* bench/iesl_host.sv */
`timescale 1ns/100ps
module iesl_host (
   input  wire logic       clk,
   input  wire logic       clr,
   input  wire logic       stall,
   input  wire logic       valid,
   input  wire logic       sym,
   input  wire logic [1:0] field,
   input  wire logic [15:0] value,
   output logic            ready,
   output logic [3:0]      seen,
   output logic            bad,
   output logic [15:0]     cond_seen,
   output logic [15:0]     count_seen
);
   // stalls come from the bench so a slow host is exercised too
   assign ready = !stall;
   always_ff @(posedge clk) begin
      if (clr) begin
         seen <= 4'h0;
         bad  <= 1'b0;
         cond_seen  <= 16'h0000;
         count_seen <= 16'h0000;
      end else if (valid && ready) begin
         seen <= seen + 4'h1;
         bad  <= bad | (field != seen[1:0]) | (sym != seen[2]);
         if (field == 2'h0) cond_seen <= value;
         if (field == 2'h3) count_seen <= value;
      end
   end
endmodule // iesl_host

/* bench/iesl_status_link_test.sv */
`timescale 1ns/100ps
module iesl_status_link_test;
   import iesl_pkg::*;
   logic clk = 0, nrst = 0, reinit = 0, cv = 0, ha = 0, me = 0, xd = 0;
   logic rxv = 0, ins = 0, sc = 1, stall = 0, clr = 1, rdy, bad, bk, ea, ro, roe, iv, isy;
   logic [2:0] arg = 0, sec;
   logic [3:0] rxe = 0, seen;
   logic [14:0] cf = 0;
   logic [15:0] xc = 0, rval, cw, xt, ival, hc, hn;
   logic bv, ev, rv;
   logic [31:0] lf = 32'hf8a8_8e02;
   logic [4:0] bec;
   logic [1:0] ifl;
   iesl_op_type op = IESL_OP_STATUS;
   int fails = 0, checks = 0, cyc = 0;
   iesl_status_link dut (.CLK(clk), .NRST(nrst), .REINIT(reinit), .CMD_VALID(cv),
      .CMD_OP(op), .CMD_HAS_ARG(ha), .CMD_ARG(arg), .MSG_END(me), .MSG_BUS_ERR(5'h00),
      .XFER_DONE(xd), .XFER_COUNT(xc), .RX_VALID(rxv), .RX_IN_STRING(ins),
      .RX_PARITY_ERR(rxe[0]), .RX_OVERRUN_ERR(rxe[1]), .RX_FRAMING_ERR(rxe[2]),
      .RX_OVERFLOW_ERR(rxe[3]), .SYS_CTRL(sc), .COND_FLAGS(cf), .ITEM_READY(rdy),
      .BYTE_VALID(bv), .BYTE_KEEP(bk), .EXEC_VALID(ev), .EXEC_ALLOW(ea), .REPLY_VALID(rv),
      .REPLY_VALUE(rval), .REN_OUT(ro), .REN_OE_N(roe), .COND_WORD(cw),
      .BUS_ERR_CODE(bec), .SER_ERR_CODE(sec), .XFER_TOTAL(xt), .ITEM_VALID(iv),
      .ITEM_SYM(isy), .ITEM_FIELD(ifl), .ITEM_VALUE(ival));
   iesl_host host (.clk(clk), .clr(clr), .stall(stall), .valid(iv), .sym(isy),
      .field(ifl), .value(ival), .ready(rdy), .seen(seen), .bad(bad),
      .cond_seen(hc), .count_seen(hn));
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one command strobe, or one message end, then let its updates land
   task automatic cmd(input iesl_op_type o, input logic h, input logic [2:0] a);
      @(posedge clk) {op, ha, arg, cv} <= {o, h, a, 1'b1};
      @(posedge clk) cv <= 0;
      #1;
   endtask
   task automatic fin;
      @(posedge clk) me <= 1;
      @(posedge clk) me <= 0;
      #1 chk("exec", ev, 1);
   endtask
   task automatic rx(input logic [3:0] e, input logic k);
      @(posedge clk) {rxv, ins, rxe} <= {2'b11, e};
      @(posedge clk) {rxv, rxe} <= 0;
      #1 chk("keep", bk, k);
      chk("bvalid", bv, 1);
   endtask
   task automatic rep(input logic [3:0] n, input logic [15:0] c, k);
      repeat (60) @(posedge clk);
      chk("items", seen, n);
      chk("order", bad, 0);
      chk("cond item", hc, c);
      chk("count item", hn, k);
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
   endtask
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      lf = nx(lf);
      stall <= lf[0];
      cyc++;
      if (cyc == 6000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      {nrst, clr} <= 2'b10;
      cmd(IESL_OP_IGNORE_ERR, 0, 0);
      chk("ignore", rval, 1);
      chk("rvalid", rv, 1);
      chk("ren_oe", roe, 1);
      rx(4'h1, 1);
      fin;
      chk("serial", sec, IESL_NO_LINK_FAULT);
      chk("allow", ea, 1);
      cmd(IESL_OP_IGNORE_ERR, 1, 0);
      fin;
      cmd(IESL_OP_IGNORE_ERR, 0, 0);
      chk("ignore", rval, 0);
      for (int i = 0; i < 4; i++) begin
         rx(4'h0, 1);
         rx(4'h1 << i, 0);
         rx(4'h0, 0);
         fin;
         chk("serial", sec, i == 0 ? IESL_PARITY_FAULT : i == 1 ? IESL_OVERRUN_FAULT :
             i == 2 ? IESL_FRAMING_FAULT : IESL_BUFFER_OVERFLOW_FAULT);
         chk("allow", ea, 0);
         chk("err", cw[15], 1);
      end
      $display("link error test done");
      cmd(IESL_OP_REMOTE_EN, 1, 1);
      fin;
      chk("ren", {ro, roe}, 0);
      @(posedge clk) sc <= 0;
      cmd(IESL_OP_REMOTE_EN, 1, 0);
      fin;
      chk("ren", roe, 0);
      chk("bus", bec, IESL_NOT_SYS_CTRL_FAULT);
      @(posedge clk) cf <= lf[14:0];
      cmd(IESL_OP_REMOTE_EN, 0, 0);
      chk("remote", rval, cf[6]);
      chk("rvalid", rv, 1);
      fin;
      chk("cond", cw[14:0], cf & 15'h71ff);
      @(posedge clk) sc <= 1;
      cmd(IESL_OP_REMOTE_EN, 1, 0);
      fin;
      chk("ren", roe, 1);
      $display("remote test done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) {xc, xd} <= {lf[15:0], 1'b1};
         @(posedge clk) xd <= 0;
         #1 chk("count", xt, xc);
      end
      cmd(IESL_OP_STATUS, 1, 3'b011);
      fin;
      rep(8, {1'b0, cf & 15'h71ff}, xc);
      cmd(IESL_OP_STATUS, 1, 3'b101);
      fin;
      rep(4, {1'b0, cf & 15'h71ff}, xc);
      @(posedge clk) cf <= lf[14:0] & 15'h7fbf;
      fin;
      rep(4, {1'b0, cf & 15'h71ff}, xc);
      cmd(IESL_OP_STATUS, 0, 0);
      fin;
      fin;
      rep(0, 0, 0);
      @(posedge clk) reinit <= 1;
      @(posedge clk) reinit <= 0;
      cmd(IESL_OP_IGNORE_ERR, 0, 0);
      chk("ignore", rval, 1);
      $display("status test done");
      final_report;
   end
endmodule // iesl_status_link_test
